// ==== logic/irsu_pkg.sv ====
// Shared constants and types for the infrared serial UART
package irsu_pkg;

    // ************************************************************
    // Clock and line rate
    // ************************************************************
    localparam int unsigned CLK_HZ    = 20_000_000;
    localparam int unsigned BAUD_RATE = 115_200;
    // Cycles per bit, rounded to nearest (0.2 percent rate error)
    localparam int unsigned BAUD_DIV  = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
    localparam logic [7:0]  BIT_CYCLES  = 8'(BAUD_DIV - 1);
    localparam logic [7:0]  HALF_CYCLES = 8'(BAUD_DIV / 2 - 1);
    localparam logic [2:0]  LAST_BIT    = 3'h7;

    // ************************************************************
    // FIFO geometry
    // ************************************************************
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned COUNT_W  = 9;
    localparam logic [8:0]  FIFO_FULL  = 9'h100;
    localparam logic [8:0]  IRQ_THRESH = 9'h01F;

    // ************************************************************
    // Register map and field positions
    // ************************************************************
    localparam logic [31:0] DATA_ADDR = 32'hFF20_1020;
    localparam logic [31:0] CTRL_ADDR = 32'hFF20_1024;
    localparam int unsigned COUNT_LSB  = 16;
    localparam int unsigned RVALID_BIT = 15;
    localparam int unsigned RX_IRQ_ENABLE_BIT   = 0;
    localparam int unsigned WE_BIT              = 1;
    localparam int unsigned RX_IRQ_PENDING_BIT  = 8;
    localparam int unsigned TX_IRQ_PENDING_BIT  = 9;
    localparam logic        RX_IRQ_ENABLE_RESET = 1'b0;
    localparam logic        WE_RESET            = 1'b0;

    // ************************************************************
    // Serializer states
    // ************************************************************
    typedef enum logic [1:0] {
        SER_IDLE,
        SER_START,
        SER_DATA,
        SER_STOP
    } irsu_ser_type;

endpackage : irsu_pkg

// ==== logic/irsu_fifo_mem.sv ====
// Character store with registered read port and write-through bypass
`timescale 1ns/1ps
`default_nettype none

module irsu_fifo_mem (
    input  wire logic                        clk,
    input  wire logic                        we,
    input  wire logic [irsu_pkg::ADDR_W-1:0] waddr,
    input  wire logic [irsu_pkg::DATA_W-1:0] wdata,
    input  wire logic [irsu_pkg::ADDR_W-1:0] raddr,
    output var  logic [irsu_pkg::DATA_W-1:0] rdata
);

    logic [irsu_pkg::DATA_W-1:0] mem [0:(1 << irsu_pkg::ADDR_W) - 1];

    // Bypass keeps the head valid the cycle after a push into an empty FIFO
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule : irsu_fifo_mem

`default_nettype wire

// ==== logic/irsu_uart.sv ====
// Infrared serial UART with APB registers and two 256-entry FIFOs
//
// Function
// - Characters are 8 data bits, no parity, one stop bit, at 115200 baud both ways.
// - Exactly two 32-bit registers exist: data at the lower word, control at the next.
// - Every received character with a high stop bit goes into a receive FIFO (up to 256 characters) while it holds fewer than 256.
// - The receive fill count reads in bits 23 to 16 of the data register.
// - A character arriving while the receive FIFO is full is thrown away.
// - Bit 15 of the data register is 1 whenever a received character is waiting.
// - A data read returns and pops the head character, with the fill count already less one.
// - A data read on an empty receive FIFO shows valid 0 and pops nothing.
// - A write to data bits 7 to 0 queues the character in a 256-entry transmit FIFO.
// - A data write never touches the receive FIFO, its count or its valid flag.
// - The transmit free space reads in bits 23 to 16 of the control register.
// - A character written while the transmit FIFO is full is dropped.
// - Each interrupt request rises only when enabled and its count (receive fill, transmit free space) exceeds 31.
// - Pending flags mirror the requests and fall when data movement ends the condition.
`timescale 1ns/1ps
`default_nettype none

module irsu_uart (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        ir_rxd,
    output var  logic        ir_txd,
    output var  logic        rx_irq_req,
    output var  logic        tx_irq_req
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Counts above 255 do not fit the 8-bit field
    function automatic logic [7:0] sat8(input logic [8:0] v);
        return v[8] ? 8'hFF : v[7:0];
    endfunction : sat8

    function automatic logic [8:0] next_count(input logic [8:0] c,
                                              input logic push,
                                              input logic pop);
        return 9'(c + {8'h00, push} - {8'h00, pop});
    endfunction : next_count

    // ************************************************************
    // Declarations
    // ************************************************************
    logic                 pready_q, pready_d;
    logic [31:0]          prdata_q, prdata_d;
    logic                 pslverr_q, pslverr_d;
    logic                 rd_pop_q, rd_pop_d;
    logic                 rx_irq_enable_q, rx_irq_enable_d, we_q, we_d;
    logic                 rx_irq_q, rx_irq_d, tx_irq_q, tx_irq_d;
    logic                 access, done, is_data, is_ctrl;
    logic [7:0]           rx_wr_q, rx_wr_d, rx_rd_q, rx_rd_d;
    logic [8:0]           rx_count_q, rx_count_d;
    logic [7:0]           tx_wr_q, tx_wr_d, tx_rd_q, tx_rd_d;
    logic [8:0]           tx_count_q, tx_count_d;
    logic                 rx_push, rx_pop, tx_push, tx_pop;
    logic [7:0]           rx_head, tx_head;
    irsu_pkg::irsu_ser_type tx_st_q, tx_st_d, rx_st_q, rx_st_d;
    logic [7:0]           tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
    logic [2:0]           tx_idx_q, tx_idx_d, rx_idx_q, rx_idx_d;
    logic [7:0]           tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
    logic                 tx_line_q, tx_line_d;
    logic                 rxd_s1_q, rxd_s2_q, rxd_prev_q;
    logic                 rx_good;

    // ************************************************************
    // APB slave
    // ************************************************************
    assign access  = psel && penable;
    assign done    = access && pready_q;
    assign is_data = (paddr == irsu_pkg::DATA_ADDR);
    assign is_ctrl = (paddr == irsu_pkg::CTRL_ADDR);
    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // Read data is captured in the first access cycle, answer in the second
    always_comb begin
        pready_d  = access && !pready_q;
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        rd_pop_d  = rd_pop_q;
        rx_irq_enable_d = rx_irq_enable_q;
        we_d      = we_q;
        if (access && !pready_q) begin
            pslverr_d = !(is_data || is_ctrl);
            rd_pop_d  = !pwrite && is_data && (rx_count_q != 9'h000);
            prdata_d  = 32'h0000_0000;
            if (!pwrite && is_data && (rx_count_q != 9'h000)) begin
                prdata_d[irsu_pkg::COUNT_LSB +: 8] =
                    sat8(9'(rx_count_q - 9'h001));
                prdata_d[irsu_pkg::RVALID_BIT]     = 1'b1;
                prdata_d[7:0]                      = rx_head;
            end else if (!pwrite && is_ctrl) begin
                prdata_d[irsu_pkg::COUNT_LSB +: 8] =
                    sat8(9'(irsu_pkg::FIFO_FULL - tx_count_q));
                prdata_d[irsu_pkg::TX_IRQ_PENDING_BIT] = tx_irq_q;
                prdata_d[irsu_pkg::RX_IRQ_PENDING_BIT] = rx_irq_q;
                prdata_d[irsu_pkg::WE_BIT]             = we_q;
                prdata_d[irsu_pkg::RX_IRQ_ENABLE_BIT]  = rx_irq_enable_q;
            end
        end
        if (done && pwrite && is_ctrl) begin
            rx_irq_enable_d = pwdata[irsu_pkg::RX_IRQ_ENABLE_BIT];
            we_d = pwdata[irsu_pkg::WE_BIT];
        end
        if (done) begin
            rd_pop_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            rd_pop_q  <= 1'b0;
            rx_irq_enable_q <= irsu_pkg::RX_IRQ_ENABLE_RESET;
            we_q      <= irsu_pkg::WE_RESET;
        end else begin
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            rd_pop_q  <= rd_pop_d;
            rx_irq_enable_q <= rx_irq_enable_d;
            we_q      <= we_d;
        end
    end

    a_bus_decode: assert property (@(posedge pclk) disable iff (!presetn)
        done && !is_data && !is_ctrl |-> pslverr)
        else $error("unmapped access not flagged");

    // ************************************************************
    // FIFO pointers and counts
    // ************************************************************
    assign rx_push = rx_good && (rx_count_q != irsu_pkg::FIFO_FULL);
    assign rx_pop  = done && rd_pop_q;
    assign tx_push = done && pwrite && is_data &&
                     (tx_count_q != irsu_pkg::FIFO_FULL);

    // A data write drives only the transmit side
    always_comb begin
        rx_wr_d    = rx_push ? 8'(rx_wr_q + 8'h01) : rx_wr_q;
        rx_rd_d    = rx_pop ? 8'(rx_rd_q + 8'h01) : rx_rd_q;
        rx_count_d = next_count(rx_count_q, rx_push, rx_pop);
        tx_wr_d    = tx_push ? 8'(tx_wr_q + 8'h01) : tx_wr_q;
        tx_rd_d    = tx_pop ? 8'(tx_rd_q + 8'h01) : tx_rd_q;
        tx_count_d = next_count(tx_count_q, tx_push, tx_pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_wr_q    <= 8'h00;
            rx_rd_q    <= 8'h00;
            rx_count_q <= 9'h000;
            tx_wr_q    <= 8'h00;
            tx_rd_q    <= 8'h00;
            tx_count_q <= 9'h000;
        end else begin
            rx_wr_q    <= rx_wr_d;
            rx_rd_q    <= rx_rd_d;
            rx_count_q <= rx_count_d;
            tx_wr_q    <= tx_wr_d;
            tx_rd_q    <= tx_rd_d;
            tx_count_q <= tx_count_d;
        end
    end

    // Read address is the next head, so the memory output is always the head
    irsu_fifo_mem u_rx_mem (
        .clk   (pclk),
        .we    (rx_push),
        .waddr (rx_wr_q),
        .wdata (rx_sh_q),
        .raddr (rx_rd_d),
        .rdata (rx_head)
    );

    irsu_fifo_mem u_tx_mem (
        .clk   (pclk),
        .we    (tx_push),
        .waddr (tx_wr_q),
        .wdata (pwdata[7:0]),
        .raddr (tx_rd_d),
        .rdata (tx_head)
    );

    a_rx_push_cnt: assert property (@(posedge pclk) disable iff (!presetn)
        rx_good && (rx_count_q < irsu_pkg::FIFO_FULL) && !rx_pop
        |=> rx_count_q == $past(rx_count_q) + 9'h001)
        else $error("received character not stored");

    a_rx_full_drop: assert property (@(posedge pclk) disable iff (!presetn)
        rx_good && (rx_count_q == irsu_pkg::FIFO_FULL) && !rx_pop
        |=> $stable(rx_count_q) && $stable(rx_wr_q))
        else $error("full receive FIFO accepted a character");

    a_rd_pop_cnt: assert property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && is_data && prdata[irsu_pkg::RVALID_BIT] && !rx_push
        |=> rx_count_q == $past(rx_count_q) - 9'h001)
        else $error("data read did not pop");

    a_empty_rd: assert property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && is_data && !prdata[irsu_pkg::RVALID_BIT]
        |=> rx_count_q == $past(rx_count_q) + {8'h00, $past(rx_push)})
        else $error("empty read changed receive count");

    a_wr_keeps_rx: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && !rx_push |=> $stable(rx_count_q) && $stable(rx_rd_q))
        else $error("write disturbed receive FIFO");

    a_tx_push_cnt: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && is_data && (tx_count_q < irsu_pkg::FIFO_FULL) && !tx_pop
        |=> tx_count_q == $past(tx_count_q) + 9'h001)
        else $error("written character not queued");

    a_tx_full_drop: assert property (@(posedge pclk) disable iff (!presetn)
        done && pwrite && is_data && (tx_count_q == irsu_pkg::FIFO_FULL)
        |=> $stable(tx_wr_q))
        else $error("full transmit FIFO accepted a write");

    // ************************************************************
    // Interrupt requests
    // ************************************************************
    // Registered from next counts, so flags track the counts in step
    always_comb begin
        rx_irq_d = rx_irq_enable_d &&
                   (rx_count_d > irsu_pkg::IRQ_THRESH);
        tx_irq_d = we_d && (9'(irsu_pkg::FIFO_FULL - tx_count_d) > irsu_pkg::IRQ_THRESH);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_irq_q <= 1'b0;
            tx_irq_q <= 1'b0;
        end else begin
            rx_irq_q <= rx_irq_d;
            tx_irq_q <= tx_irq_d;
        end
    end

    assign rx_irq_req = rx_irq_q;
    assign tx_irq_req = tx_irq_q;

    a_rx_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        rx_irq_req |-> rx_irq_enable_q && (rx_count_q > irsu_pkg::IRQ_THRESH))
        else $error("receive request without cause");

    a_tx_irq_clr: assert property (@(posedge pclk) disable iff (!presetn)
        we_q && (tx_count_q >= 9'h0E1) |-> !tx_irq_req)
        else $error("transmit pending stuck");

    // ************************************************************
    // Transmitter
    // ************************************************************
    assign tx_pop = (tx_st_q == irsu_pkg::SER_IDLE) && (tx_count_q != 9'h000);
    assign ir_txd = tx_line_q;

    // tx_cnt_q is the baud divider for every bit; tx_idx_q counts the data bits
    always_comb begin
        tx_st_d   = tx_st_q;
        tx_cnt_d  = 8'(tx_cnt_q - 8'h01);
        tx_idx_d  = tx_idx_q;
        tx_sh_d   = tx_sh_q;
        tx_line_d = tx_line_q;
        case (tx_st_q)
            irsu_pkg::SER_IDLE: begin
                tx_cnt_d  = irsu_pkg::BIT_CYCLES;
                tx_line_d = 1'b1;
                if (tx_pop) begin
                    tx_sh_d   = tx_head;
                    tx_line_d = 1'b0;
                    tx_st_d   = irsu_pkg::SER_START;
                end
            end
            irsu_pkg::SER_START: begin
                if (tx_cnt_q == 8'h00) begin
                    tx_cnt_d  = irsu_pkg::BIT_CYCLES;
                    tx_line_d = tx_sh_q[0];
                    tx_idx_d  = 3'h0;
                    tx_st_d   = irsu_pkg::SER_DATA;
                end
            end
            irsu_pkg::SER_DATA: begin
                if (tx_cnt_q == 8'h00) begin
                    tx_cnt_d  = irsu_pkg::BIT_CYCLES;
                    tx_sh_d   = {1'b0, tx_sh_q[7:1]};
                    tx_line_d = tx_sh_q[1];
                    tx_idx_d  = 3'(tx_idx_q + 3'h1);
                    if (tx_idx_q == irsu_pkg::LAST_BIT) begin
                        tx_line_d = 1'b1;
                        tx_st_d   = irsu_pkg::SER_STOP;
                    end
                end
            end
            irsu_pkg::SER_STOP: begin
                if (tx_cnt_q == 8'h00) begin
                    tx_st_d = irsu_pkg::SER_IDLE;
                end
            end
            default: begin
                tx_st_d   = irsu_pkg::SER_IDLE;
                tx_line_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q   <= irsu_pkg::SER_IDLE;
            tx_cnt_q  <= 8'h00;
            tx_idx_q  <= 3'h0;
            tx_sh_q   <= 8'h00;
            tx_line_q <= 1'b1;
        end else begin
            tx_st_q   <= tx_st_d;
            tx_cnt_q  <= tx_cnt_d;
            tx_idx_q  <= tx_idx_d;
            tx_sh_q   <= tx_sh_d;
            tx_line_q <= tx_line_d;
        end
    end

    a_tx_idle_high: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_st_q == irsu_pkg::SER_IDLE) && $past(tx_st_q == irsu_pkg::SER_IDLE) |-> ir_txd)
        else $error("idle line not high");

    a_tx_start_len: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ir_txd) && (tx_st_q == irsu_pkg::SER_START) |-> (!ir_txd) [*8])
        else $error("start bit too short");

    // ************************************************************
    // Receiver
    // ************************************************************
    // Two-stage synchroniser; only the second stage and its delayed copy rxd_prev_q feed logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_s1_q   <= 1'b1;
            rxd_s2_q   <= 1'b1;
            rxd_prev_q <= 1'b1;
        end else begin
            rxd_s1_q   <= ir_rxd;
            rxd_s2_q   <= rxd_s1_q;
            rxd_prev_q <= rxd_s2_q;
        end
    end

    assign rx_good = (rx_st_q == irsu_pkg::SER_STOP) && (rx_cnt_q == 8'h00) && rxd_s2_q;

    // A glitch shorter than half a bit is rejected at the start check
    always_comb begin
        rx_st_d  = rx_st_q;
        rx_cnt_d = 8'(rx_cnt_q - 8'h01);
        rx_idx_d = rx_idx_q;
        rx_sh_d  = rx_sh_q;
        case (rx_st_q)
            irsu_pkg::SER_IDLE: begin
                rx_cnt_d = irsu_pkg::HALF_CYCLES;
                if (rxd_prev_q && !rxd_s2_q) begin
                    rx_st_d = irsu_pkg::SER_START;
                end
            end
            irsu_pkg::SER_START: begin
                if (rx_cnt_q == 8'h00) begin
                    rx_cnt_d = irsu_pkg::BIT_CYCLES;
                    rx_idx_d = 3'h0;
                    rx_st_d  = rxd_s2_q ? irsu_pkg::SER_IDLE : irsu_pkg::SER_DATA;
                end
            end
            irsu_pkg::SER_DATA: begin
                if (rx_cnt_q == 8'h00) begin
                    rx_cnt_d = irsu_pkg::BIT_CYCLES;
                    rx_sh_d  = {rxd_s2_q, rx_sh_q[7:1]};
                    rx_idx_d = 3'(rx_idx_q + 3'h1);
                    if (rx_idx_q == irsu_pkg::LAST_BIT) begin
                        rx_st_d = irsu_pkg::SER_STOP;
                    end
                end
            end
            irsu_pkg::SER_STOP: begin
                if (rx_cnt_q == 8'h00) begin
                    rx_st_d = irsu_pkg::SER_IDLE;
                end
            end
            default: begin
                rx_st_d = irsu_pkg::SER_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q  <= irsu_pkg::SER_IDLE;
            rx_cnt_q <= 8'h00;
            rx_idx_q <= 3'h0;
            rx_sh_q  <= 8'h00;
        end else begin
            rx_st_q  <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
            rx_idx_q <= rx_idx_d;
            rx_sh_q  <= rx_sh_d;
        end
    end

    a_rx_bad_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_st_q == irsu_pkg::SER_STOP) && (rx_cnt_q == 8'h00) && !rxd_s2_q
        |=> $stable(rx_count_q) || $past(rx_pop))
        else $error("framing error stored");

endmodule : irsu_uart

`default_nettype wire

// ==== tb/irsu_ir_model.sv ====
// Behavioural model of the infrared transceiver at the far side of the UART
`timescale 1ns/1ps
`default_nettype none

module irsu_ir_model (
    input  wire logic       clk,
    input  wire logic       ir_txd,
    output var  logic       ir_rxd,
    output var  logic [7:0] got,
    output var  int         n_got
);
    // ****************************************
    // Serial line, 174 clocks per bit
    // ****************************************
    logic [7:0] sh;

    // Receiver output idles high between frames
    initial begin
        ir_rxd = 1'b1;
        got    = 8'h00;
        n_got  = 0;
    end

    // Start low, data LSB first, chosen stop level, then idle high
    task automatic send(input logic [7:0] ch, input logic stop);
        logic [9:0] frame;
        frame = {stop, ch, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(posedge clk);
            ir_rxd <= frame[k];
            repeat (173) @(posedge clk);
        end
        @(posedge clk);
        ir_rxd <= 1'b1;
    endtask : send

    // Mid-bit sampling; frames with a low stop bit are not counted
    always begin
        @(negedge ir_txd);
        repeat (87) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            repeat (174) @(posedge clk);
            sh[k] = ir_txd;
        end
        repeat (174) @(posedge clk);
        if (ir_txd === 1'b1) begin
            got   = sh;
            n_got = n_got + 1;
        end
    end
endmodule : irsu_ir_model
`default_nettype wire

// ==== tb/infrared_serial_uart_bench.sv ====
// Self-checking bench for the infrared serial UART
`timescale 1ns/1ps
`default_nettype none

module infrared_serial_uart_bench;
    typedef struct packed {
        logic w; logic [31:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] x; logic e;
    } irsu_row_type;
    localparam logic [31:0] DA = irsu_pkg::DATA_ADDR;
    localparam logic [31:0] CA = irsu_pkg::CTRL_ADDR;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, ir_rxd, ir_txd, rx_irq_req, tx_irq_req, er;
    logic [7:0]  got;
    int          n_got;
    int          n_mismatch = 0;
    int          n_checks = 0;
    irsu_row_type rows [6];

    irsu_uart i_irsu_uart (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ir_rxd(ir_rxd), .ir_txd(ir_txd), .rx_irq_req(rx_irq_req),
        .tx_irq_req(tx_irq_req));
    irsu_ir_model i_irsu_ir_model (.clk(pclk), .ir_txd(ir_txd), .ir_rxd(ir_rxd), .got(got),
        .n_got(n_got));

    // 20 MHz clock
    always #25 pclk = ~pclk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Setup, then hold the access until pready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : apb

    // Bounded wait for the model to decode n characters
    task automatic wait_got(input int n);
        for (int i = 0; i < 3000 && n_got < n; i++) @(posedge pclk);
        if (n_got < n) begin
            n_mismatch++;
            print_verdict();
        end
    endtask : wait_got

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rows = '{'{1'b0, CA, 32'h0000_0000, 32'h00FF_0303, 32'h00FF_0000, 1'b0},
                 '{1'b0, DA, 32'h0000_0000, 32'h00FF_8000, 32'h0000_0000, 1'b0},
                 '{1'b1, CA, 32'h0000_0003, 32'h0000_0000, 32'h0000_0000, 1'b0},
                 '{1'b0, CA, 32'h0000_0000, 32'h00FF_0303, 32'h00FF_0203, 1'b0},
                 '{1'b0, 32'hFF20_1028, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
                 '{1'b1, 32'hFF20_101C, 32'h0000_0041, 32'h0000_0000, 32'h0000_0000, 1'b1}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            check("row data", rd & rows[i].m, rows[i].x);
            check("row error", 32'(er), 32'(rows[i].e));
        end
        check("tx irq", 32'(tx_irq_req), 32'h0000_0001);
        $display("register rows done");
        // Two good frames, one with a low stop bit, then a write before the reads
        i_irsu_ir_model.send(8'hA5, 1'b1);
        i_irsu_ir_model.send(8'h3C, 1'b1);
        i_irsu_ir_model.send(8'h77, 1'b0);
        repeat (10) @(posedge pclk);
        apb(1'b1, DA, 32'h0000_005A);
        apb(1'b0, DA, 32'h0000_0000);
        check("rx first", rd & 32'h00FF_80FF, 32'h0001_80A5);
        apb(1'b0, DA, 32'h0000_0000);
        check("rx second", rd & 32'h00FF_80FF, 32'h0000_803C);
        apb(1'b0, DA, 32'h0000_0000);
        check("rx empty", rd & 32'h00FF_8000, 32'h0000_0000);
        check("rx irq", 32'(rx_irq_req), 32'h0000_0000);
        wait_got(1);
        check("tx char", 32'(got), 32'h0000_005A);
        $display("serial frames done");
        // Flood past capacity; the last write must be dropped
        for (int k = 0; k < 258; k++) apb(1'b1, DA, 32'(k[7:0]));
        apb(1'b0, CA, 32'h0000_0000);
        check("tx full", rd & 32'h00FF_0200, 32'h0000_0000);
        check("tx irq off", 32'(tx_irq_req), 32'h0000_0000);
        wait_got(2);
        check("tx order", 32'(got), 32'h0000_0000);
        $display("transmit flood done");
        // Reset with a full transmit FIFO in mid-frame; both FIFOs and enables clear
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("reset txd", 32'(ir_txd), 32'h0000_0001);
        check("reset outs", 32'({rx_irq_req, tx_irq_req, pready}), 32'h0000_0000);
        presetn <= 1'b1;
        apb(1'b0, CA, 32'h0000_0000);
        check("reset ctrl", rd & 32'h00FF_0303, 32'h00FF_0000);
        apb(1'b0, DA, 32'h0000_0000);
        check("reset data", rd & 32'h00FF_8000, 32'h0000_0000);
        $display("mid-run reset done");
        print_verdict();
    end

    // Guard against a hang anywhere
    initial begin
        repeat (100000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
endmodule : infrared_serial_uart_bench
`default_nettype wire
